// ===== hw/line_cfg_defines.svh
`ifndef LINE_CFG_DEFINES_SVH
`define LINE_CFG_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CHG_IRQ_ENABLE   12'h000
`define OFS_CHG_IRQ_DISABLE  12'h004
`define OFS_CHG_IRQ_MASK     12'h008
`define OFS_CHG_IRQ_STATUS   12'h00C
`define OFS_OD_ENABLE        12'h010
`define OFS_OD_DISABLE       12'h014
`define OFS_OD_STATE         12'h018
`define OFS_PU_DISABLE       12'h020
`define OFS_PU_ENABLE        12'h024
`define OFS_PU_STATE         12'h028
`define OFS_PA_SELECT        12'h030
`define OFS_PB_SELECT        12'h034
`define OFS_PSEL_STATE       12'h038
`define OFS_DW_ENABLE        12'h040
`define OFS_DW_DISABLE       12'h044
`define OFS_DW_STATE         12'h048
`define OFS_OUT_DATA_STATE   12'h04C

// ------------------------------------------------------------
// Decode and reset values
// ------------------------------------------------------------
`define ADDR_DEC_W           12
`define RST_MASK             32'h0000_0000
`define RST_STATUS           32'h0000_0000
`define RST_OD               32'h0000_0000
`define RST_PU_DIS           32'h0000_0000
`define RST_PSEL             32'h0000_0000
`define RST_DW               32'h0000_0000
`define RST_OUT_DATA         32'h0000_0000
`define HTRANS_NONSEQ_BIT    1
`define HRESP_OKAY           1'h0

`endif

// ===== hw/line_cfg_pkg.sv
package line_cfg_pkg;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef logic [31:0] line_vec_t;

  typedef enum {
    SEL_NONE,
    SEL_IRQ_EN,
    SEL_IRQ_DIS,
    SEL_IRQ_MASK,
    SEL_IRQ_STAT,
    SEL_OD_EN,
    SEL_OD_DIS,
    SEL_OD_STATE,
    SEL_PU_DIS,
    SEL_PU_EN,
    SEL_PU_STATE,
    SEL_PA,
    SEL_PB,
    SEL_PSEL_STATE,
    SEL_DW_EN,
    SEL_DW_DIS,
    SEL_DW_STATE,
    SEL_OUT_DATA
  } reg_sel_t;

endpackage : line_cfg_pkg

// ===== hw/line_cfg_if.sv
`timescale 1ns/10ps
// Carries synchronised line levels and change pulses to the core
interface line_cfg_if;
  line_cfg_pkg::line_vec_t level;
  line_cfg_pkg::line_vec_t change;

  modport detect (output level, output change);
  modport core (input level, input change);
endinterface : line_cfg_if

// ===== hw/line_change_detect.sv
`timescale 1ns/10ps
module line_change_detect #(
  parameter int LINES = 32
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Raw pins
  input wire logic [LINES-1:0] line_in,
  // Toward the core
  line_cfg_if.detect det
);

  logic [LINES-1:0] meta_ff;
  logic [LINES-1:0] sync_ff;
  logic [LINES-1:0] prev_ff;
  logic primed_ff;

  // ------------------------------------------------------------
  // Two-stage synchroniser; meta_ff feeds only sync_ff
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= line_in;
      sync_ff <= meta_ff;
    end
  end

  // History; primed on the first enabled cycle after reset, before the synchroniser has filled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= '0;
      primed_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= sync_ff;
      primed_ff <= 1'b1;
    end
  end

  // Any edge counts; gated only before the first enabled cycle, so a line high from reset still flags one change
  assign det.level = sync_ff;
  assign det.change = primed_ff ? (sync_ff ^ prev_ff) : '0;

endmodule : line_change_detect

// ===== hw/io_line_config_and_change_irq.sv
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
// What this block does
// - Ones written to change-irq disable clear those mask bits; zeros ignored.
// - Ones written to change-irq enable set those mask bits.
// - Mask register reads one per line with change interrupt enabled.
// - Status bit reads one after any input change since last read or reset.
// - Reading status clears all bits; reset clears them too.
// - Ones written to open-drain enable turn on open-drain for those lines.
// - Ones written to open-drain disable turn off open-drain for those lines.
// - Open-drain on: state reads one and pin only driven low.
// - Open-drain off: state reads zero and pin driven high and low.
// - Ones written to pull-up disable switch that line's pull-up off.
// - Ones written to pull-up enable switch that line's pull-up on.
// - Pull-up state reads zero when enabled, one when disabled.
// - Ones written to peripheral-A select assign those lines to A.
// - Ones written to peripheral-B select assign those lines to B.
// - Peripheral select state reads zero for A, one for B.
// - Zero bits in any set, clear or select write change nothing.
// - Direct-write enable ones let output data writes change those lines.
// - Direct-write disable ones block output data writes on those lines.
// - Direct-write state reads one where output data writes take effect.
`include "line_cfg_defines.svh"

module io_line_config_and_change_irq #(
  parameter int LINES = 32
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,

  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,

  // I/O lines
  input wire logic [LINES-1:0] line_in,
  output logic [LINES-1:0] line_out,
  output logic [LINES-1:0] line_oe,
  output logic [LINES-1:0] line_pullup_en,
  output logic [LINES-1:0] line_periph_b,

  // Interrupt to the system controller
  output logic change_irq
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  line_cfg_if lines_if ();

  logic [LINES-1:0] mask_ff;
  logic [LINES-1:0] status_ff;
  logic [LINES-1:0] od_ff;
  logic [LINES-1:0] pu_dis_ff;
  logic [LINES-1:0] psel_ff;
  logic [LINES-1:0] dw_ff;
  logic [LINES-1:0] out_data_ff;
  logic [LINES-1:0] nxt_status;
  logic [LINES-1:0] wr_ones;

  logic wr_pend_ff;
  line_cfg_pkg::reg_sel_t wr_sel_ff;
  line_cfg_pkg::reg_sel_t addr_sel;
  logic access;
  logic rd_access;
  logic wr_access;
  logic [31:0] nxt_rdata;

  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [LINES-1:0] line_out_ff;
  logic [LINES-1:0] line_oe_ff;
  logic [LINES-1:0] pullup_ff;
  logic [LINES-1:0] periph_b_ff;
  logic change_irq_ff;

  // ------------------------------------------------------------
  // Input synchroniser and change detector
  // ------------------------------------------------------------
  line_change_detect #(
    .LINES(LINES)
  ) u_detect (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .line_in(line_in),
    .det(lines_if)
  );

  // ------------------------------------------------------------
  // Address phase decode
  // ------------------------------------------------------------
  // Only whole-word transfers are mapped; others read zero and write nothing
  always_comb begin
    addr_sel = line_cfg_pkg::SEL_NONE;
    if (hsize == 3'h2) begin
      case (haddr[`ADDR_DEC_W-1:0])
        `OFS_CHG_IRQ_ENABLE: addr_sel = line_cfg_pkg::SEL_IRQ_EN;
        `OFS_CHG_IRQ_DISABLE: addr_sel = line_cfg_pkg::SEL_IRQ_DIS;
        `OFS_CHG_IRQ_MASK: addr_sel = line_cfg_pkg::SEL_IRQ_MASK;
        `OFS_CHG_IRQ_STATUS: addr_sel = line_cfg_pkg::SEL_IRQ_STAT;
        `OFS_OD_ENABLE: addr_sel = line_cfg_pkg::SEL_OD_EN;
        `OFS_OD_DISABLE: addr_sel = line_cfg_pkg::SEL_OD_DIS;
        `OFS_OD_STATE: addr_sel = line_cfg_pkg::SEL_OD_STATE;
        `OFS_PU_DISABLE: addr_sel = line_cfg_pkg::SEL_PU_DIS;
        `OFS_PU_ENABLE: addr_sel = line_cfg_pkg::SEL_PU_EN;
        `OFS_PU_STATE: addr_sel = line_cfg_pkg::SEL_PU_STATE;
        `OFS_PA_SELECT: addr_sel = line_cfg_pkg::SEL_PA;
        `OFS_PB_SELECT: addr_sel = line_cfg_pkg::SEL_PB;
        `OFS_PSEL_STATE: addr_sel = line_cfg_pkg::SEL_PSEL_STATE;
        `OFS_DW_ENABLE: addr_sel = line_cfg_pkg::SEL_DW_EN;
        `OFS_DW_DISABLE: addr_sel = line_cfg_pkg::SEL_DW_DIS;
        `OFS_DW_STATE: addr_sel = line_cfg_pkg::SEL_DW_STATE;
        `OFS_OUT_DATA_STATE: addr_sel = line_cfg_pkg::SEL_OUT_DATA;
        default: addr_sel = line_cfg_pkg::SEL_NONE;
      endcase
    end
  end

  // Transfer accepted on a NONSEQ/SEQ with hready high
  assign access = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready & ce;
  assign rd_access = access & ~hwrite;
  assign wr_access = access & hwrite;

  // ------------------------------------------------------------
  // Write address capture for the data phase
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_sel_ff <= line_cfg_pkg::SEL_NONE;
    end else if (ce) begin
      wr_pend_ff <= wr_access;
      wr_sel_ff <= wr_access ? addr_sel : line_cfg_pkg::SEL_NONE;
    end
  end

  // Data phase payload; zero bits never act on any line
  assign wr_ones = wr_pend_ff ? hwdata[LINES-1:0] : '0;

  // ------------------------------------------------------------
  // Change interrupt mask
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_ff <= `RST_MASK;
    end else if (ce) begin
      if (wr_sel_ff == line_cfg_pkg::SEL_IRQ_EN) begin
        mask_ff <= mask_ff | wr_ones;
      end else if (wr_sel_ff == line_cfg_pkg::SEL_IRQ_DIS) begin
        mask_ff <= mask_ff & ~wr_ones;
      end
    end
  end

  // ------------------------------------------------------------
  // Change status, clear on read
  // ------------------------------------------------------------
  // A change in the same cycle as the clearing read is kept for next read
  always_comb begin
    nxt_status = status_ff;
    if (rd_access && addr_sel == line_cfg_pkg::SEL_IRQ_STAT) begin
      nxt_status = '0;
    end
    nxt_status = nxt_status | lines_if.change;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= `RST_STATUS;
    end else if (ce) begin
      status_ff <= nxt_status;
    end
  end

  // ------------------------------------------------------------
  // Open-drain control
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      od_ff <= `RST_OD;
    end else if (ce) begin
      if (wr_sel_ff == line_cfg_pkg::SEL_OD_EN) begin
        od_ff <= od_ff | wr_ones;
      end else if (wr_sel_ff == line_cfg_pkg::SEL_OD_DIS) begin
        od_ff <= od_ff & ~wr_ones;
      end
    end
  end

  // ------------------------------------------------------------
  // Pull-up control, stored as a disable bit
  // ------------------------------------------------------------
  // Storing the disable sense lets the state register read it directly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pu_dis_ff <= `RST_PU_DIS;
    end else if (ce) begin
      if (wr_sel_ff == line_cfg_pkg::SEL_PU_DIS) begin
        pu_dis_ff <= pu_dis_ff | wr_ones;
      end else if (wr_sel_ff == line_cfg_pkg::SEL_PU_EN) begin
        pu_dis_ff <= pu_dis_ff & ~wr_ones;
      end
    end
  end

  // ------------------------------------------------------------
  // Peripheral A/B select
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psel_ff <= `RST_PSEL;
    end else if (ce) begin
      if (wr_sel_ff == line_cfg_pkg::SEL_PA) begin
        psel_ff <= psel_ff & ~wr_ones;
      end else if (wr_sel_ff == line_cfg_pkg::SEL_PB) begin
        psel_ff <= psel_ff | wr_ones;
      end
    end
  end

  // ------------------------------------------------------------
  // Direct output write gating and output data
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dw_ff <= `RST_DW;
    end else if (ce) begin
      if (wr_sel_ff == line_cfg_pkg::SEL_DW_EN) begin
        dw_ff <= dw_ff | wr_ones;
      end else if (wr_sel_ff == line_cfg_pkg::SEL_DW_DIS) begin
        dw_ff <= dw_ff & ~wr_ones;
      end
    end
  end

  // Unlike the pairs, this write takes zeros too, but only on gated lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_data_ff <= `RST_OUT_DATA;
    end else if (ce) begin
      if (wr_pend_ff && wr_sel_ff == line_cfg_pkg::SEL_OUT_DATA) begin
        out_data_ff <= (out_data_ff & ~dw_ff) | (hwdata[LINES-1:0] & dw_ff);
      end
    end
  end

  // ------------------------------------------------------------
  // Read data mux
  // ------------------------------------------------------------
  // Sampled in the address phase, so it shows state before a write in flight
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (addr_sel)
      line_cfg_pkg::SEL_IRQ_MASK: nxt_rdata[LINES-1:0] = mask_ff;
      line_cfg_pkg::SEL_IRQ_STAT: nxt_rdata[LINES-1:0] = status_ff;
      line_cfg_pkg::SEL_OD_STATE: nxt_rdata[LINES-1:0] = od_ff;
      line_cfg_pkg::SEL_PU_STATE: nxt_rdata[LINES-1:0] = pu_dis_ff;
      line_cfg_pkg::SEL_PSEL_STATE: nxt_rdata[LINES-1:0] = psel_ff;
      line_cfg_pkg::SEL_DW_STATE: nxt_rdata[LINES-1:0] = dw_ff;
      line_cfg_pkg::SEL_OUT_DATA: nxt_rdata[LINES-1:0] = out_data_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      hrdata_ff <= rd_access ? nxt_rdata : 32'h0000_0000;
    end
  end

  // Zero wait states; no transfer is ever stretched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
    end else begin
      hreadyout_ff <= 1'b1;
    end
  end

  // Error responses are never raised; a flop keeps the pin glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_ff <= `HRESP_OKAY;
    end else begin
      hresp_ff <= `HRESP_OKAY;
    end
  end

  // ------------------------------------------------------------
  // Pad drive, one instance of the logic per line
  // ------------------------------------------------------------
  // Open-drain lines release the pin for a one and pull low for a zero
  for (genvar i = 0; i < LINES; i++) begin : g_pad
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        line_out_ff[i] <= 1'b0;
        line_oe_ff[i] <= 1'b1;
        pullup_ff[i] <= 1'b1;
        periph_b_ff[i] <= 1'b0;
      end else if (ce) begin
        line_out_ff[i] <= out_data_ff[i];
        line_oe_ff[i] <= od_ff[i] ? ~out_data_ff[i] : 1'b1;
        pullup_ff[i] <= ~pu_dis_ff[i];
        periph_b_ff[i] <= psel_ff[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt output
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      change_irq_ff <= 1'b0;
    end else if (ce) begin
      change_irq_ff <= |(status_ff & mask_ff);
    end
  end

  // ------------------------------------------------------------
  // Output assignments
  // ------------------------------------------------------------
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign line_out = line_out_ff;
  assign line_oe = line_oe_ff;
  assign line_pullup_en = pullup_ff;
  assign line_periph_b = periph_b_ff;
  assign change_irq = change_irq_ff;

endmodule : io_line_config_and_change_irq

// ===== tb/line_partner.sv
`timescale 1ns/10ps
module line_partner #(
  parameter int LINES = 32
) (
  // Clock
  input wire logic hclk,
  // Pads of the block
  input wire logic [LINES-1:0] line_out,
  input wire logic [LINES-1:0] line_oe,
  input wire logic [LINES-1:0] line_pullup_en,
  // Outside drivers
  input wire logic [LINES-1:0] ext_en,
  input wire logic [LINES-1:0] ext_val,
  // Level at the pads
  output logic [LINES-1:0] line_in
);
  logic [LINES-1:0] flt_ff = {LINES{1'b0}};

  // Floating lines wander, so an unknown never settles quietly
  always @(posedge hclk) begin
    flt_ff <= ~flt_ff;
  end

  // Wired-AND: any low driver beats pull-up and outside high
  assign line_in = ~(line_oe & ~line_out) & ((ext_en & ext_val) |
    (~ext_en & ((line_oe & line_out) | (~line_oe & (line_pullup_en | flt_ff)))));
endmodule : line_partner

// ===== tb/io_line_cfg_assertions.sv
`timescale 1ns/10ps
module io_line_cfg_assertions #(
  parameter int LINES = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Lines
  input wire logic [LINES-1:0] line_in,
  input wire logic [LINES-1:0] line_out,
  input wire logic [LINES-1:0] line_oe,
  input wire logic [LINES-1:0] line_pullup_en,
  input wire logic [LINES-1:0] line_periph_b,
  input wire logic change_irq
);
  logic take;
  logic stat_rd;
  logic wr_ff;
  logic rd_ff;
  logic [11:0] a_ff;
  logic [31:0] exp_ff;
  logic [31:0] shd_ff [6];
  logic [31:0] prev_ff;
  logic [3:0] calm_ff;

  // Shadow slot of a readable register; 6 reads as zero
  function automatic int idx(input logic [11:0] a);
    case (a)
      12'h008: idx = 0;
      12'h018: idx = 1;
      12'h028: idx = 2;
      12'h038: idx = 3;
      12'h048: idx = 4;
      12'h04C: idx = 5;
      default: idx = 6;
    endcase
  endfunction : idx

  // Transfer taken only for word size
  assign take = hsel & htrans[1] & hready & ce & (hsize == 3'h2);
  assign stat_rd = take & ~hwrite & (haddr[11:0] == 12'h00C);

  // Expected data grabbed before a pending write lands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      a_ff <= 12'h000;
      exp_ff <= 32'h0000_0000;
    end else if (ce) begin
      wr_ff <= take & hwrite;
      rd_ff <= take & ~hwrite & (haddr[11:0] != 12'h00C);
      a_ff <= haddr[11:0];
      exp_ff <= (idx(haddr[11:0]) < 6) ? shd_ff[idx(haddr[11:0])] : 32'h0000_0000;
    end
  end

  // Shadow state; pull-up slot holds the disabled sense
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shd_ff <= '{default: 32'h0000_0000};
    end else if (wr_ff && ce) begin
      case (a_ff)
        12'h000: shd_ff[0] <= shd_ff[0] | hwdata;
        12'h004: shd_ff[0] <= shd_ff[0] & ~hwdata;
        12'h010: shd_ff[1] <= shd_ff[1] | hwdata;
        12'h014: shd_ff[1] <= shd_ff[1] & ~hwdata;
        12'h020: shd_ff[2] <= shd_ff[2] | hwdata;
        12'h024: shd_ff[2] <= shd_ff[2] & ~hwdata;
        12'h034: shd_ff[3] <= shd_ff[3] | hwdata;
        12'h030: shd_ff[3] <= shd_ff[3] & ~hwdata;
        12'h040: shd_ff[4] <= shd_ff[4] | hwdata;
        12'h044: shd_ff[4] <= shd_ff[4] & ~hwdata;
        12'h04C: shd_ff[5] <= (shd_ff[5] & ~shd_ff[4]) | (hwdata & shd_ff[4]);
        default: ;
      endcase
    end
  end

  // Quiet pin cycles, saturating; a change may still be in the synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= 32'h0000_0000;
      calm_ff <= 4'h0;
    end else begin
      prev_ff <= 32'(line_in);
      calm_ff <= (32'(line_in) != prev_ff) ? 4'h0 : calm_ff + {3'h0, calm_ff != 4'hF};
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  read_data_a: assert property (rd_ff |-> hrdata == exp_ff)
    else $error("register read differs from shadow");
  pullup_pin_a: assert property (line_pullup_en == ~$past(shd_ff[2][LINES-1:0]))
    else $error("pull-up pins differ from shadow");
  periph_pin_a: assert property (line_periph_b == $past(shd_ff[3][LINES-1:0]))
    else $error("peripheral select pins differ");
  out_pin_a: assert property (line_out == $past(shd_ff[5][LINES-1:0]))
    else $error("output data pins differ");
  od_pin_a: assert property (line_oe == ~($past(shd_ff[1][LINES-1:0]) & line_out))
    else $error("drive enable wrong for open-drain state");
  low_drive_a: assert property (&(line_oe | line_out))
    else $error("low level not driven");
  irq_mask_a: assert property (change_irq |-> |$past(shd_ff[0]))
    else $error("interrupt with all lines masked");
  stat_clear_a: assert property (stat_rd && calm_ff > 4'h6 |-> ##2 !change_irq)
    else $error("interrupt kept after status read");

  cover property (stat_rd ##1 hrdata != 32'h0000_0000);
  cover property ($rose(change_irq));
  cover property (rd_ff && a_ff == 12'h04C && hrdata != 32'h0000_0000);
endmodule : io_line_cfg_assertions

bind io_line_config_and_change_irq io_line_cfg_assertions #(.LINES(LINES)) chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
  .line_pullup_en(line_pullup_en), .line_periph_b(line_periph_b), .change_irq(change_irq)
);

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] ext_en = 32'h0000_0000;
  logic [31:0] ext_val = 32'h0000_0000;
  logic [31:0] junk;
  logic hreadyout;
  logic hresp;
  logic change_irq;
  logic [31:0] hrdata;
  logic [31:0] line_in;
  logic [31:0] line_out;
  logic [31:0] line_oe;
  logic [31:0] line_pullup_en;
  logic [31:0] line_periph_b;
  int fails = 0;
  int tests_run = 0;

  // 10 MHz bus clock
  always #50 hclk = ~hclk;

  // Single slave: its ready is the bus ready
  io_line_config_and_change_irq #(.LINES(32)) DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .line_pullup_en(line_pullup_en), .line_periph_b(line_periph_b), .change_irq(change_irq)
  );
  line_partner #(.LINES(32)) pads (
    .hclk(hclk), .line_out(line_out), .line_oe(line_oe), .line_pullup_en(line_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .line_in(line_in)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Next edge with ready high; a stuck slave ends the run
  task automatic edge_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        results();
      end
      @(posedge hclk);
    end
  endtask : edge_ready

  // One single word transfer; entered right after an edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    edge_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    chk(what, exp, v);
  endtask : rdchk

  // Bounded wait for the interrupt level
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (change_irq !== lvl && n < 20) begin
      @(posedge hclk);
      n++;
    end
    chk("change_irq", {31'h0, lvl}, {31'h0, change_irq});
    if (n >= 20) begin
      results();
    end
  endtask : wait_irq

  task automatic test_reset();
    rdchk("mask", 12'h008, 32'h0000_0000);
    rdchk("od_state", 12'h018, 32'h0000_0000);
    rdchk("pu_state", 12'h028, 32'h0000_0000);
    rdchk("psel_state", 12'h038, 32'h0000_0000);
    rdchk("dw_state", 12'h048, 32'h0000_0000);
    rdchk("status", 12'h00C, 32'h0000_0000);
    rdchk("unmapped", 12'h05C, 32'h0000_0000);
    chk("pullup_pins", 32'hFFFF_FFFF, line_pullup_en);
    chk("oe_pins", 32'hFFFF_FFFF, line_oe);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    $display("test_reset done");
  endtask : test_reset

  // Every set/clear pair: ones act, zeros leave state alone
  task automatic test_pairs();
    logic [11:0] set_a [5] = '{12'h000, 12'h010, 12'h020, 12'h034, 12'h040};
    logic [11:0] clr_a [5] = '{12'h004, 12'h014, 12'h024, 12'h030, 12'h044};
    logic [11:0] st_a [5] = '{12'h008, 12'h018, 12'h028, 12'h038, 12'h048};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, set_a[i], 32'hA5A5_0F0F, junk);
      bus(1'b1, set_a[i], 32'h0000_0000, junk);
      bus(1'b1, clr_a[i], 32'h0000_FFFF, junk);
      bus(1'b1, clr_a[i], 32'h0000_0000, junk);
      rdchk("pair_state", st_a[i], 32'hA5A5_0000);
    end
    chk("pullup_pins", 32'h5A5A_FFFF, line_pullup_en);
    chk("periph_b_pins", 32'hA5A5_0000, line_periph_b);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, clr_a[i], 32'hFFFF_FFFF, junk);
    end
    $display("test_pairs done");
  endtask : test_pairs

  task automatic test_direct();
    bus(1'b1, 12'h040, 32'h0000_FFFF, junk);
    bus(1'b1, 12'h04C, 32'hFFFF_FFFF, junk);
    rdchk("out_data", 12'h04C, 32'h0000_FFFF);
    bus(1'b1, 12'h010, 32'h0000_00FF, junk);
    rdchk("dw_state", 12'h048, 32'h0000_FFFF);
    chk("line_out", 32'h0000_FFFF, line_out);
    chk("line_oe", 32'hFFFF_FF00, line_oe);
    bus(1'b1, 12'h014, 32'h0000_000F, junk);
    rdchk("od_state", 12'h018, 32'h0000_00F0);
    chk("line_oe", 32'hFFFF_FF0F, line_oe);
    $display("test_direct done");
  endtask : test_direct

  // Lines 4 and 5 pulled low outside; only line 4 unmasked
  task automatic test_change();
    rdchk("status", 12'h00C, 32'h0000_FFFF);
    rdchk("status", 12'h00C, 32'h0000_0000);
    bus(1'b1, 12'h000, 32'h0000_0010, junk);
    ext_en <= 32'h0000_0030;
    wait_irq(1'b1);
    rdchk("status", 12'h00C, 32'h0000_0030);
    wait_irq(1'b0);
    bus(1'b1, 12'h004, 32'h0000_0010, junk);
    ext_en <= 32'h0000_0000;
    repeat (8) @(posedge hclk);
    chk("irq_masked", 32'h0000_0000, {31'h0, change_irq});
    rdchk("status", 12'h00C, 32'h0000_0030);
    $display("test_change done");
  endtask : test_change

  task automatic results();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Reset for 8 cycles, first request one edge after release
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset();
    test_pairs();
    test_direct();
    test_change();
    results();
  end
endmodule : tb_top
